// [logic/aspc_pkg.sv]
// package of constants for the audio serial pin control block
package aspc_pkg;
  // register byte offsets
  localparam logic [7:0] ASPC_CTRL_OFF     = 8'h00; // control: masters, enables, soft reset, stop
  localparam logic [7:0] ASPC_STATUS_OFF   = 8'h04; // pin states seen by the block
  localparam logic [7:0] ASPC_DIV_OFF      = 8'h08; // bit clock divider
  localparam logic [7:0] ASPC_TXDATA_OFF   = 8'h0c; // transmit data bits
  // control field positions
  localparam int ASPC_CTRL_RX_MASTER = 0;
  localparam int ASPC_CTRL_TX_MASTER = 1;
  localparam int ASPC_CTRL_RX_EN_LO  = 2;
  localparam int ASPC_CTRL_TX_EN_LO  = 4;
  localparam int ASPC_CTRL_SOFT_RST  = 7;
  localparam int ASPC_CTRL_STOP      = 8;
  // widths and counts
  localparam int ASPC_NUM_RX = 2;
  localparam int ASPC_NUM_TX = 3;
  localparam int ASPC_CTRL_W = 9;
  localparam int ASPC_DIV_W  = 8;
  // reset values
  localparam logic [ASPC_CTRL_W-1:0] ASPC_CTRL_RESET = 9'h000;
  localparam logic [ASPC_DIV_W-1:0]  ASPC_DIV_RESET  = 8'h03;
  localparam logic [2:0]             ASPC_TXD_RESET  = 3'h7;
  // ahb-lite codes
  localparam logic [1:0] ASPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ASPC_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] ASPC_HSIZE_WORD    = 3'h2;
endpackage : aspc_pkg

// [logic/aspc_clk_div.sv]
// divider making enable pulses and a master clock level
`timescale 1ns/1ps
module aspc_clk_div
  import aspc_pkg::*;
#(
  parameter int DIV_W = aspc_pkg::ASPC_DIV_W
)(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // control
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] half_period_i,
  // outputs
  output logic                  clk_level_o,
  output logic                  fall_en_o
);
  // whole state
  typedef struct packed
  {
    logic [DIV_W-1:0] count; // cycles left in half period
    logic             level; // generated clock level
    logic             fall;  // one-cycle falling enable
  } aspc_div_state_type;

  aspc_div_state_type state;
  aspc_div_state_type next_state;

  // next state
  always_comb
  begin
    next_state      = state;
    next_state.fall = 1'b0;
    if (!run_i)
    begin
      // idle low, restart cleanly
      next_state.count = half_period_i;
      next_state.level = 1'b0;
    end
    else if (state.count == '0)
    begin
      // toggle at end of half period
      next_state.count = half_period_i;
      next_state.level = ~state.level;
      next_state.fall  = state.level;
    end
    else
    begin
      next_state.count = state.count - 1'b1;
    end
  end

  // register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign clk_level_o = state.level;
  assign fall_en_o   = state.fall;
endmodule : aspc_clk_div

// [logic/aspc_top.sv]
// audio serial pin control with ahb-lite registers
// Summary of operation
// (R1) rx master drives rx word select
// (R2) rx word select frames words, left/right
// (R3) rx word select floats when off/reset/stop
// (R4) tx outputs driven high when idle/reset/stop
// (R5) tx master drives tx bit clock
// (R6) master supplies clock, slave takes external
// (R7) tx bit clock floats when off/reset/stop
// (R8) tx master drives tx word select
// (R9) tx word select frames words, left/right
// (R10) tx word select floats when off/reset/stop
// (R11) rx master drives rx bit clock
// (R12) disabled receiver input disconnected
// (R13) separate master bits and enables
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module aspc_top
  import aspc_pkg::*;
#(
  parameter int NUM_RX  = aspc_pkg::ASPC_NUM_RX,
  parameter int WORD_W  = 16
)(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // ahb-lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  // receive pins
  input  wire logic                 rx_bit_clock_i,
  output logic                      rx_bit_clock_o,
  output logic                      rx_bit_clock_oe_n_o,
  input  wire logic                 rx_word_select_i,
  output logic                      rx_word_select_o,
  output logic                      rx_word_select_oe_n_o,
  input  wire logic [NUM_RX-1:0]    rx_serial_in_i,
  // transmit pins
  input  wire logic                 tx_bit_clock_i,
  output logic                      tx_bit_clock_o,
  output logic                      tx_bit_clock_oe_n_o,
  input  wire logic                 tx_word_select_i,
  output logic                      tx_word_select_o,
  output logic                      tx_word_select_oe_n_o,
  output logic                      tx_serial_out_a_o,
  output logic                      tx_serial_out_b_o,
  output logic                      tx_serial_out_c_o
);
  import aspc_pkg::*;

  // word select toggles every WORD_W bit clocks
  localparam logic [7:0] WORD_LAST = 8'(WORD_W - 1);

  // whole state
  typedef struct packed
  {
    logic                     ph_valid;   // data phase pending
    logic                     ph_write;   // pending is a write
    logic [7:0]               ph_addr;    // pending byte offset
    logic [ASPC_CTRL_W-1:0]   ctrl;       // control register
    logic [ASPC_DIV_W-1:0]    div;        // divider half period
    logic [2:0]               txd;        // transmit data bits
    logic [31:0]              rdata;      // read data
    logic [1:0]               rxck_s;     // rx bit clock sync
    logic [1:0]               rxws_s;     // rx word select sync
    logic [1:0]               txck_s;     // tx bit clock sync
    logic [1:0]               txws_s;     // tx word select sync
    logic [NUM_RX-1:0]        rxd_s1;     // rx data sync stage one
    logic [NUM_RX-1:0]        rxd_s2;     // rx data sync stage two
    logic                     rxck_d;     // rx clock previous level
    logic                     txck_d;     // tx clock previous level
    logic [7:0]               rx_bits;    // rx bits in word
    logic [7:0]               tx_bits;    // tx bits in word
    logic                     rx_ws;      // generated rx word select
    logic                     tx_ws;      // generated tx word select
    logic                     rxck_o;     // rx clock pin out
    logic                     rxck_oe_n;  // rx clock enable
    logic                     rxws_o;     // rx word select pin out
    logic                     rxws_oe_n;  // rx word select enable
    logic                     txck_o;     // tx clock pin out
    logic                     txck_oe_n;  // tx clock enable
    logic                     txws_o;     // tx word select out
    logic                     txws_oe_n;  // tx word select enable
    logic [2:0]               sdo;        // tx data pins
    logic [NUM_RX-1:0]        rx_sample;  // last sampled rx data
  } aspc_state_type;

  // registered state and its next value
  aspc_state_type state;
  aspc_state_type next_state;

  // decoded control
  logic              rx_master;
  logic              tx_master;
  logic [NUM_RX-1:0] rx_en;
  logic [2:0]        tx_en;
  logic              halted;
  logic              rx_live;
  logic              tx_live;
  logic              rx_gen;
  logic              tx_gen;
  logic              rx_fall;
  logic              tx_fall;
  logic              addr_ok;

  // each section picks master or slave on its own bit
  assign rx_master = state.ctrl[ASPC_CTRL_RX_MASTER]; // R13
  assign tx_master = state.ctrl[ASPC_CTRL_TX_MASTER]; // R13
  // one enable per receiver and per transmitter
  assign rx_en     = state.ctrl[ASPC_CTRL_RX_EN_LO +: NUM_RX]; // R13
  assign tx_en     = state.ctrl[ASPC_CTRL_TX_EN_LO +: 3]; // R13
  // soft reset and stop both park every pin
  assign halted    = state.ctrl[ASPC_CTRL_SOFT_RST] | state.ctrl[ASPC_CTRL_STOP];
  // all enables off is the individual reset of a section
  assign rx_live   = (|rx_en) & ~halted;
  assign tx_live   = (|tx_en) & ~halted;

  // master clock generators
  aspc_clk_div #(.DIV_W(ASPC_DIV_W)) u_rx_div
  (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .run_i         (rx_live & rx_master),
    .half_period_i (state.div),
    .clk_level_o   (rx_gen),
    .fall_en_o     (rx_fall)
  );

  aspc_clk_div #(.DIV_W(ASPC_DIV_W)) u_tx_div
  (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .run_i         (tx_live & tx_master),
    .half_period_i (state.div),
    .clk_level_o   (tx_gen),
    .fall_en_o     (tx_fall)
  );

  // offsets that hold a register; anything else reads zero
  // and swallows writes, still answering okay
  assign addr_ok = (haddr_i[7:0] == ASPC_CTRL_OFF) | (haddr_i[7:0] == ASPC_STATUS_OFF) |
                   (haddr_i[7:0] == ASPC_DIV_OFF)  | (haddr_i[7:0] == ASPC_TXDATA_OFF);

  // next state
  always_comb
  begin
    logic rx_tick;
    logic tx_tick;
    rx_tick    = 1'b0;
    tx_tick    = 1'b0;
    next_state = state;
    // two-flop synchronisers for every pin input
    // first stage is read by nothing but the second
    next_state.rxck_s = {state.rxck_s[0], rx_bit_clock_i};
    next_state.rxws_s = {state.rxws_s[0], rx_word_select_i};
    next_state.txck_s = {state.txck_s[0], tx_bit_clock_i};
    next_state.txws_s = {state.txws_s[0], tx_word_select_i};
    // data pins pass two flops untouched; the enable gate
    // sits behind the second one so no logic sees a raw pin
    next_state.rxd_s1 = rx_serial_in_i;
    next_state.rxd_s2 = state.rxd_s1;
    // previous clock levels for falling edge detection
    next_state.rxck_d = state.rxck_s[1];
    next_state.txck_d = state.txck_s[1];

    // bus data phase: the write lands at the end of it,
    // pins follow one edge later
    if (state.ph_valid && state.ph_write)
    begin
      if (state.ph_addr == ASPC_CTRL_OFF)
        next_state.ctrl = hwdata_i[ASPC_CTRL_W-1:0];
      else if (state.ph_addr == ASPC_DIV_OFF)
        next_state.div = hwdata_i[ASPC_DIV_W-1:0];
      else if (state.ph_addr == ASPC_TXDATA_OFF)
        next_state.txd = hwdata_i[2:0];
    end
    // bus address phase: zero wait, so every request is taken
    // read data registered here, standing for the data phase only
    next_state.ph_valid = hsel_i & hready_i & htrans_i[1];
    next_state.ph_write = hwrite_i;
    next_state.ph_addr  = haddr_i[7:0];
    next_state.rdata    = '0;
    if (hsel_i && hready_i && htrans_i[1] && !hwrite_i && addr_ok)
    begin
      if (haddr_i[7:0] == ASPC_CTRL_OFF)
        next_state.rdata = 32'(state.ctrl);
      else if (haddr_i[7:0] == ASPC_STATUS_OFF)
        next_state.rdata = 32'({state.rx_sample, state.tx_ws, state.txck_o, state.rx_ws, state.rxck_o});
      else if (haddr_i[7:0] == ASPC_DIV_OFF)
        next_state.rdata = 32'(state.div);
      else
        next_state.rdata = 32'(state.txd);
    end

    // receive clock: own divider as master, pin as slave
    if (rx_master)
      rx_tick = rx_fall; // R6
    else
      // slave: falling edge of the synchronised pin
      rx_tick = state.rxck_d & ~state.rxck_s[1];
    if (!rx_live)
    begin
      // section idle: framing restarts at the left word
      next_state.rx_bits = '0;
      next_state.rx_ws   = 1'b0;
    end
    else if (rx_tick)
    begin
      // disabled receivers are disconnected and read low
      next_state.rx_sample = state.rxd_s2 & rx_en; // R12
      // word select frames each word, low left, high right
      if (!rx_master)
        // slave: follow the far side's word select
        next_state.rx_ws = state.rxws_s[1]; // R2
      else if (state.rx_bits == WORD_LAST)
        next_state.rx_ws = ~state.rx_ws; // R2
      next_state.rx_bits = (state.rx_bits == WORD_LAST) ? 8'h00 : state.rx_bits + 8'h01;
    end

    // transmit clock: own divider as master, pin as slave
    if (tx_master)
      tx_tick = tx_fall; // R6
    else
      // slave: falling edge of the synchronised pin
      tx_tick = state.txck_d & ~state.txck_s[1]; // R6
    if (!tx_live)
    begin
      // section idle: framing restarts at the left word
      next_state.tx_bits = '0;
      next_state.tx_ws   = 1'b0;
    end
    else if (tx_tick)
    begin
      if (!tx_master)
        // slave: follow the far side's word select
        next_state.tx_ws = state.txws_s[1]; // R9
      else if (state.tx_bits == WORD_LAST)
        next_state.tx_ws = ~state.tx_ws; // R9
      next_state.tx_bits = (state.tx_bits == WORD_LAST) ? 8'h00 : state.tx_bits + 8'h01;
    end

    // receive pin drivers
    // driven only as a live master; otherwise the pin floats
    next_state.rxck_o    = rx_live & rx_master & rx_gen;
    next_state.rxck_oe_n = ~(rx_live & rx_master); // R11
    next_state.rxws_o    = rx_live & rx_master & state.rx_ws;
    next_state.rxws_oe_n = ~(rx_live & rx_master); // R1 R3

    // transmit pin drivers
    next_state.txck_o    = tx_live & tx_master & tx_gen;
    next_state.txck_oe_n = ~(tx_live & tx_master); // R5 R7
    next_state.txws_o    = tx_live & tx_master & state.tx_ws;
    next_state.txws_oe_n = ~(tx_live & tx_master); // R8 R10
    // data pins sit high unless that transmitter runs
    for (int i = 0; i < 3; i++)
      next_state.sdo[i] = ~(tx_en[i] & ~halted) | state.txd[i]; // R4
  end

  // register, hardware reset floats pins and drives data high
  // synchronous reset; the whole state moves on one edge
  // so pin direction and pin value never disagree
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state           <= '0;
      state.ctrl      <= ASPC_CTRL_RESET;
      state.div       <= ASPC_DIV_RESET;
      state.txd       <= ASPC_TXD_RESET;
      state.rxck_oe_n <= 1'b1; // R3
      state.rxws_oe_n <= 1'b1; // R3
      state.txck_oe_n <= 1'b1; // R7
      state.txws_oe_n <= 1'b1; // R10
      state.sdo       <= 3'h7; // R4
    end
    else
      state <= next_state;
  end

  // outputs straight from flops
  // bus never stalls and never errors
  assign hrdata_o              = state.rdata;
  assign hreadyout_o           = 1'b1;
  assign hresp_o               = 1'b0;
  assign rx_bit_clock_o        = state.rxck_o;
  assign rx_bit_clock_oe_n_o   = state.rxck_oe_n;
  assign rx_word_select_o      = state.rxws_o;
  assign rx_word_select_oe_n_o = state.rxws_oe_n;
  assign tx_bit_clock_o        = state.txck_o;
  assign tx_bit_clock_oe_n_o   = state.txck_oe_n;
  assign tx_word_select_o      = state.txws_o;
  assign tx_word_select_oe_n_o = state.txws_oe_n;
  assign tx_serial_out_a_o     = state.sdo[0];
  assign tx_serial_out_b_o     = state.sdo[1];
  assign tx_serial_out_c_o     = state.sdo[2];
endmodule : aspc_top

// [tb/aspc_partner.sv]
// behavioural codec standing on the serial side of the block
`timescale 1ns/1ps
module aspc_partner (
  // control from the bench
  input  wire logic       run_i,
  // codec pins
  output logic            bit_clock_o,
  output logic            word_select_o,
  output logic [1:0]      data_o
);
  int n_fall; // falling clock edges within the current word
  // 80 ns bit clock, standing still low while run_i is low
  initial
  begin
    bit_clock_o = 1'b0;
    word_select_o = 1'b0;
    data_o = 2'h0;
    n_fall = 0;
    #3;
    forever
    begin
      #40;
      bit_clock_o = run_i ? ~bit_clock_o : 1'b0;
      if (run_i && !bit_clock_o)
        n_fall++;
      if (n_fall == 16)
      begin
        word_select_o = ~word_select_o;
        n_fall = 0;
      end
      // released data lines keep changing so no stale value passes
      data_o = run_i ? 2'h3 : ~data_o;
    end
  end
endmodule : aspc_partner

// [tb/aspc_top_props.sv]
// assertions on the bus and pins of the audio serial pin control
`timescale 1ns/1ps
module aspc_top_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // bus
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // pins
  input wire logic        rx_bit_clock_oe_n_o,
  input wire logic        rx_word_select_oe_n_o,
  input wire logic        tx_bit_clock_oe_n_o,
  input wire logic        tx_word_select_oe_n_o,
  input wire logic        tx_bit_clock_o,
  input wire logic        tx_serial_out_a_o,
  input wire logic        tx_serial_out_b_o,
  input wire logic        tx_serial_out_c_o
);
  logic wr_q; // a write is in its data phase
  // track writes so pin changes can be tied to them
  always_ff @(posedge clk_i)
    wr_q <= reset_n_i & hsel_i & hready_i & htrans_i[1] & hwrite_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rst_float;
    disable iff (1'b0) !reset_n_i |=> &{rx_bit_clock_oe_n_o, rx_word_select_oe_n_o,
      tx_bit_clock_oe_n_o, tx_word_select_oe_n_o};
  endproperty
  property p_rst_sdo;
    disable iff (1'b0) !reset_n_i |=> &{tx_serial_out_a_o, tx_serial_out_b_o, tx_serial_out_c_o};
  endproperty
  property p_rdata_rst;
    disable iff (1'b0) !reset_n_i ##1 !reset_n_i |-> hrdata_o == 32'h0;
  endproperty
  property p_bus_ok;
    hreadyout_o && !hresp_o;
  endproperty
  property p_rx_pair;
    rx_bit_clock_oe_n_o == rx_word_select_oe_n_o;
  endproperty
  property p_tx_pair;
    tx_bit_clock_oe_n_o == tx_word_select_oe_n_o;
  endproperty
  property p_oe_cause;
    $changed({rx_word_select_oe_n_o, tx_bit_clock_oe_n_o}) |-> $past(wr_q) || $past(wr_q, 2);
  endproperty
  property p_sdo_cause;
    $changed({tx_serial_out_a_o, tx_serial_out_b_o, tx_serial_out_c_o}) |-> $past(wr_q) || $past(wr_q, 2);
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("pins not floating in reset");
  a_rst_sdo: assert property (p_rst_sdo) else $error("data out not high in reset");
  a_rdata_rst: assert property (p_rdata_rst) else $error("read data not zero in reset");
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  a_rx_pair: assert property (p_rx_pair) else $error("rx clock and word select disagree");
  a_tx_pair: assert property (p_tx_pair) else $error("tx clock and word select disagree");
  a_oe_cause: assert property (p_oe_cause) else $error("pin direction changed without write");
  a_sdo_cause: assert property (p_sdo_cause) else $error("data out changed without write");
  c_tx_master: cover property (!tx_bit_clock_oe_n_o && $rose(tx_bit_clock_o));
  c_rx_master: cover property (!rx_word_select_oe_n_o);
  c_sdo_low: cover property (!tx_serial_out_a_o);
endmodule : aspc_top_props
bind aspc_top aspc_top_props aspc_top_props_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_bit_clock_oe_n_o(rx_bit_clock_oe_n_o),
  .rx_word_select_oe_n_o(rx_word_select_oe_n_o), .tx_bit_clock_oe_n_o(tx_bit_clock_oe_n_o),
  .tx_word_select_oe_n_o(tx_word_select_oe_n_o), .tx_bit_clock_o(tx_bit_clock_o),
  .tx_serial_out_a_o(tx_serial_out_a_o), .tx_serial_out_b_o(tx_serial_out_b_o),
  .tx_serial_out_c_o(tx_serial_out_c_o));

// [tb/aspc_tb_top.sv]
// self-checking testbench of the audio serial pin control
`timescale 1ns/1ps
module aspc_tb_top;
  import aspc_pkg::*;
  logic        clk_i, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, p_run = 1'b0, v;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd, hrdata_s;
  logic [1:0]  htrans_i = 2'h0, p_data;
  logic        hreadyout_o, hresp_o, p_clk, p_ws;
  logic        rx_clk, rx_clk_oe_n, rx_ws, rx_ws_oe_n, tx_clk, tx_clk_oe_n, tx_ws, tx_ws_oe_n;
  logic [2:0]  sdo;
  int          n_errors = 0, n_compared = 0, n;
  int          n_bits [2] = '{ASPC_CTRL_SOFT_RST, ASPC_CTRL_STOP}; // soft reset and stop bits
  localparam int WORD_BITS = 16; // bit clocks in each word select half
  // device under test, pins resolved against the codec
  aspc_top aspc_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(ASPC_HSIZE_WORD), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .rx_bit_clock_i(rx_clk_oe_n ? p_clk : rx_clk), .rx_bit_clock_o(rx_clk), .rx_bit_clock_oe_n_o(rx_clk_oe_n),
    .rx_word_select_i(rx_ws_oe_n ? p_ws : rx_ws), .rx_word_select_o(rx_ws), .rx_word_select_oe_n_o(rx_ws_oe_n),
    .rx_serial_in_i(p_data), .tx_bit_clock_i(tx_clk_oe_n ? p_clk : tx_clk), .tx_bit_clock_o(tx_clk),
    .tx_bit_clock_oe_n_o(tx_clk_oe_n), .tx_word_select_i(tx_ws_oe_n ? p_ws : tx_ws), .tx_word_select_o(tx_ws),
    .tx_word_select_oe_n_o(tx_ws_oe_n), .tx_serial_out_a_o(sdo[0]), .tx_serial_out_b_o(sdo[1]),
    .tx_serial_out_c_o(sdo[2]));
  aspc_partner aspc_partner_inst (.run_i(p_run), .bit_clock_o(p_clk), .word_select_o(p_ws), .data_o(p_data));
  // 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // read data as it stood before each edge
  always @(posedge clk_i) hrdata_s <= hrdata_o;
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one single ahb-lite transfer, waiting on hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    // start right after an edge; the address phase then waits for hready
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    htrans_i <= ASPC_HTRANS_NONSEQ;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    #1 rd = hrdata_s;
  endtask : ahb
  // write, then let the pins follow
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    @(posedge clk_i);
    #1;
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(nm, exp, rd);
  endtask : rdchk
  // pin vector: rx clk oe, rx ws oe, tx clk oe, tx ws oe, data c b a
  task automatic pins(input logic [6:0] exp);
    check("pins", {25'h0, exp}, {25'h0, rx_clk_oe_n, rx_ws_oe_n, tx_clk_oe_n, tx_ws_oe_n, sdo});
  endtask : pins
  // cycles between two changes of one generated pin: 0 tx clk, 1 rx clk, 2 rx ws, 3 tx ws
  task automatic span(input int sel, input int lim, input logic [31:0] exp, input string nm);
    logic [3:0] p;
    p = {tx_ws, rx_ws, rx_clk, tx_clk};
    repeat (2)
    begin
      v = p[sel];
      for (n = 0; n < lim && p[sel] === v; n++)
      begin
        @(posedge clk_i);
        #1;
        p = {tx_ws, rx_ws, rx_clk, tx_clk};
      end
    end
    check(nm, exp, 32'(n));
  endtask : span
  task automatic t_reset();
    pins(7'h7f);
    rdchk("ctrl", ASPC_CTRL_OFF, 32'h0);
    rdchk("div", ASPC_DIV_OFF, {24'h0, ASPC_DIV_RESET});
    rdchk("txdata", ASPC_TXDATA_OFF, {29'h0, ASPC_TXD_RESET});
    wr(8'h10, 32'hffff_ffff);
    rdchk("unmapped", 8'h10, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx_slave();
    p_run <= 1'b1;
    wr(ASPC_TXDATA_OFF, 32'h0);
    wr(ASPC_CTRL_OFF, 32'h70);
    pins(7'h78);
    n = 0;
    // status bit 3 is the word select taken at each slave clock fall
    repeat (200)
    begin
      v = rd[3];
      ahb(1'b0, ASPC_STATUS_OFF, 32'h0);
      n += int'(rd[3] !== v);
    end
    check("slave clock seen", 32'h1, {31'h0, n > 1});
    wr(ASPC_CTRL_OFF, 32'h50);
    pins(7'h7a);
    wr(ASPC_CTRL_OFF, 32'h0);
    pins(7'h7f);
    $display("test tx slave done");
  endtask : t_tx_slave
  task automatic t_master();
    wr(ASPC_CTRL_OFF, 32'h17);
    pins(7'h06);
    span(0, 50, 32'(ASPC_DIV_RESET) + 32'h1, "tx half period");
    span(1, 50, 32'(ASPC_DIV_RESET) + 32'h1, "rx half period");
    span(2, 300, 32'(2 * WORD_BITS) * (32'(ASPC_DIV_RESET) + 32'h1), "rx word");
    span(3, 300, 32'(2 * WORD_BITS) * (32'(ASPC_DIV_RESET) + 32'h1), "tx word");
    foreach (n_bits[i])
    begin
      wr(ASPC_CTRL_OFF, 32'h17 | (32'h1 << n_bits[i]));
      pins(7'h7f);
      wr(ASPC_CTRL_OFF, 32'h17);
      pins(7'h06);
    end
    wr(ASPC_CTRL_OFF, 32'h03);
    pins(7'h7f);
    wr(ASPC_CTRL_OFF, 32'h15);
    pins(7'h1e);
    $display("test master done");
  endtask : t_master
  task automatic t_rx();
    // receiver a alone, slave: b stays disconnected although driven high
    wr(ASPC_CTRL_OFF, 32'h04);
    // read well clear of a word select change so the sample is settled
    @(p_ws);
    repeat (10) @(posedge clk_i);
    #1;
    rdchk("rx sample", ASPC_STATUS_OFF, {26'h0, 2'h1, 2'h0, p_ws, 1'b0});
    pins(7'h7f);
    // receiver b alone: a now reads low
    wr(ASPC_CTRL_OFF, 32'h08);
    @(p_ws);
    repeat (10) @(posedge clk_i);
    #1;
    rdchk("rx off", ASPC_STATUS_OFF, {26'h0, 2'h2, 2'h0, p_ws, 1'b0});
    wr(ASPC_CTRL_OFF, 32'h0);
    pins(7'h7f);
    $display("test rx done");
  endtask : t_rx
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // watchdog
  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    t_reset();
    t_tx_slave();
    t_master();
    t_rx();
    finish_test();
  end
endmodule : aspc_tb_top
